// *** hdl/ppp_defines.svh ***
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH

// Command bytes
`define PPP_CMD_NOP        8'h00
`define PPP_CMD_WR_FLASH   8'h10
`define PPP_CMD_WR_EEPROM  8'h11
`define PPP_CMD_WR_FUSE    8'h40
`define PPP_CMD_WR_LOCK    8'h20
`define PPP_CMD_RD_FLASH   8'h02
`define PPP_CMD_RD_EEPROM  8'h03
`define PPP_CMD_RD_FUSE    8'h04
`define PPP_CMD_RD_ID      8'h08

// Action select codes {hi,lo}
`define PPP_ACT_ADDR       2'h0
`define PPP_ACT_DATA       2'h1
`define PPP_ACT_CMD        2'h2
`define PPP_ACT_IDLE       2'h3

// Bit positions in the synchronised pin vector
`define PPP_PIN_STB        15
`define PPP_PIN_XA_HI      14
`define PPP_PIN_XA_LO      13
`define PPP_PIN_BS1        12
`define PPP_PIN_BS2        11
`define PPP_PIN_PGL        10
`define PPP_PIN_WR_N       9
`define PPP_PIN_OE_N       8
`define PPP_PIN_W          16
`define PPP_PIN_RST        16'h0300

// Lock byte fields
`define PPP_LOCK_MAIN      8'h03
`define PPP_LOCK_BOOT      8'h3C

// Reset values
`define PPP_FUSE_LO_RST    8'hFF
`define PPP_FUSE_HI_RST    8'hFF
`define PPP_FUSE_EXT_RST   8'hFF
`define PPP_LOCK_RST       8'hFF
`define PPP_BYTE_ERASED    8'hFF

// Sizes and timing counts
`define PPP_FLASH_AW       13
`define PPP_FLASH_PWB      6
`define PPP_EE_AW          9
`define PPP_EE_PWB         2
`define PPP_BUSY_CYCLES    16

`endif

// *** hdl/ppp_pkg.sv ***
package ppp_pkg;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_COPY_FL = 4'b0010,
		ST_COPY_EE = 4'b0100,
		ST_HOLD    = 4'b1000
	} ppp_state_type;

endpackage : ppp_pkg

// *** hdl/ppp_sync.sv ***
// Three-stage pin synchroniser; a bit changes once stages two and three agree
module ppp_sync #(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] out_r;
	logic [W-1:0] out_nxt;

	// Take the agreed value, otherwise hold
	assign out_nxt  = (s2_r & s3_r) | (out_r & (s2_r | s3_r));
	assign sync_out = out_r;

	////////////////////////////////////////////////////////////////////////////
	// Stages
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r  <= RST_VAL;
			s2_r  <= RST_VAL;
			s3_r  <= RST_VAL;
			out_r <= RST_VAL;
		end else if (clk_en) begin
			s1_r  <= async_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			out_r <= out_nxt;
		end
	end

endmodule : ppp_sync

// *** hdl/ppp_port.sv ***
`include "ppp_defines.svh"
// What this block does
// - Action select 10 with strobe pulse latches data bus as command byte.
// - Command 0001 0000 selects page-buffered flash programming.
// - Action select 00 loads address byte; byte select one picks low/high.
// - Action select 01 loads data byte; byte select one picks low/high.
// - Page latch pulse with byte select one high stores data at word slot.
// - Low address bits pick word in page, upper bits pick the page.
// - Write strobe low pulse programs whole page; ready low until done.
// - Command 0000 0000 is no operation and ends page programming.
// - Command 0001 0001 is EEPROM page write, started with byte select one low.
// - Command 0000 0010 reads flash low/high byte by byte select one.
// - Command 0000 0011 reads addressed EEPROM byte with byte select one low.
// - Command 0100 0000 writes low data into fuses; zero programs.
// - Byte selects at write strobe choose low, high or extended fuse byte.
// - Command 0010 0000 writes lock bits from low data; zero programs.
// - In lock mode 3 the boot lock bits cannot be programmed.
// - Lock bits are never set back to one by any command here.
// - Command 0000 0100 reads fuses and lock by byte select pair.
// - Command 0000 1000 reads identification byte 0 to 2 by low address.
// - Identification read at address 0 with byte select one high gives calibration.
// - Command and address stay loaded across operations.
// - Ready output is 0 while busy and 1 when ready.
// - Data bus is driven only while output enable is low.
module ppp_port #(
	parameter int         FLASH_AW    = `PPP_FLASH_AW,
	parameter int         FLASH_PWB   = `PPP_FLASH_PWB,
	parameter int         EE_AW       = `PPP_EE_AW,
	parameter int         EE_PWB      = `PPP_EE_PWB,
	parameter int         BUSY_CYCLES = `PPP_BUSY_CYCLES,
	parameter logic [7:0] ID_BYTE0    = 8'h5A, // Arbitrary value
	parameter logic [7:0] ID_BYTE1    = 8'h3C, // Arbitrary value
	parameter logic [7:0] ID_BYTE2    = 8'hA5, // Arbitrary value
	parameter logic [7:0] CAL_BYTE    = 8'h80  // Arbitrary value
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       action_strobe,
	input  wire logic       action_select_hi,
	input  wire logic       action_select_lo,
	input  wire logic       byte_select_one,
	input  wire logic       byte_select_two,
	input  wire logic       page_latch_strobe,
	input  wire logic       write_n,
	input  wire logic       output_enable_n,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            ready_not_busy
);

	localparam int PAGE_WORDS = 1 << FLASH_PWB;
	localparam int FLASH_SIZE = 1 << FLASH_AW;
	localparam int EE_PAGE    = 1 << EE_PWB;
	localparam int EE_SIZE    = 1 << EE_AW;
	localparam int CNT_W      = $clog2(BUSY_CYCLES + PAGE_WORDS + 1);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [`PPP_PIN_W-1:0] pins_raw;
	logic [`PPP_PIN_W-1:0] pins_w;
	logic [`PPP_PIN_W-1:0] pins_d_r;
	logic [7:0]            cmd_r;
	logic [7:0]            addr_lo_r;
	logic [7:0]            addr_hi_r;
	logic [7:0]            dat_lo_r;
	logic [7:0]            dat_hi_r;
	logic [7:0]            fuse_lo_r;
	logic [7:0]            fuse_hi_r;
	logic [7:0]            fuse_ext_r;
	logic [7:0]            lock_r;
	logic [7:0]            dout_r;
	logic                  doe_r;
	logic                  rdy_r;
	logic [CNT_W-1:0]      cnt_r;
	logic [CNT_W-1:0]      cnt_nxt;
	logic [FLASH_PWB-1:0]  idx_r;
	logic [FLASH_AW-FLASH_PWB-1:0] page_r;
	logic [EE_AW-EE_PWB-1:0]       epage_r;
	ppp_pkg::ppp_state_type        state_r;
	ppp_pkg::ppp_state_type        state_nxt;
	logic [15:0]           pbuf_r [PAGE_WORDS];
	logic [7:0]            ebuf_r [EE_PAGE];
	logic [15:0]           flash_r [FLASH_SIZE];
	logic [7:0]            eeprom_r [EE_SIZE];

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	assign pins_raw = {action_strobe, action_select_hi, action_select_lo,
			byte_select_one, byte_select_two, page_latch_strobe,
			write_n, output_enable_n, data_in};

	ppp_sync #(
		.W       (`PPP_PIN_W),
		.RST_VAL (`PPP_PIN_RST)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.async_in (pins_raw),
		.sync_out (pins_w)
	);

	////////////////////////////////////////////////////////////////////////////
	// Pin decode and edge detection
	wire       idle_w     = (state_r == ppp_pkg::ST_IDLE);
	wire [1:0] act_w      = {pins_w[`PPP_PIN_XA_HI], pins_w[`PPP_PIN_XA_LO]};
	wire       bs1_w      = pins_w[`PPP_PIN_BS1];
	wire       bs2_w      = pins_w[`PPP_PIN_BS2];
	wire [7:0] bus_w      = pins_w[7:0];
	wire       stb_rise   = pins_w[`PPP_PIN_STB] & ~pins_d_r[`PPP_PIN_STB] & idle_w;
	wire       pgl_rise   = pins_w[`PPP_PIN_PGL] & ~pins_d_r[`PPP_PIN_PGL] & idle_w;
	wire       wr_fall    = ~pins_w[`PPP_PIN_WR_N] & pins_d_r[`PPP_PIN_WR_N] & idle_w;
	wire       oe_w       = ~pins_w[`PPP_PIN_OE_N];

	// Strobe actions by action select code
	wire ld_cmd   = stb_rise & (act_w == `PPP_ACT_CMD);
	wire ld_addr  = stb_rise & (act_w == `PPP_ACT_ADDR);
	wire ld_data  = stb_rise & (act_w == `PPP_ACT_DATA);
	// Action code 11 matches none of the loads above

	// Only defined command codes are accepted
	wire cmd_known = (bus_w == `PPP_CMD_NOP) | (bus_w == `PPP_CMD_WR_FLASH)
			| (bus_w == `PPP_CMD_WR_EEPROM) | (bus_w == `PPP_CMD_WR_FUSE)
			| (bus_w == `PPP_CMD_WR_LOCK) | (bus_w == `PPP_CMD_RD_FLASH)
			| (bus_w == `PPP_CMD_RD_EEPROM) | (bus_w == `PPP_CMD_RD_FUSE)
			| (bus_w == `PPP_CMD_RD_ID);

	// Address split into page and word fields
	wire [15:0]                addr_w   = {addr_hi_r, addr_lo_r};
	wire [FLASH_AW-1:0]        faddr_w  = addr_w[FLASH_AW-1:0];
	wire [FLASH_PWB-1:0]       fword_w  = faddr_w[FLASH_PWB-1:0];
	wire [FLASH_AW-FLASH_PWB-1:0] fpage_w = faddr_w[FLASH_AW-1:FLASH_PWB];
	wire [EE_AW-1:0]           eaddr_w  = addr_w[EE_AW-1:0];
	wire [EE_PWB-1:0]          eword_w  = eaddr_w[EE_PWB-1:0];
	wire [EE_AW-EE_PWB-1:0]    epage_w  = eaddr_w[EE_AW-1:EE_PWB];

	// Write strobe starts by command
	wire go_flash = wr_fall & (cmd_r == `PPP_CMD_WR_FLASH);
	wire go_ee    = wr_fall & (cmd_r == `PPP_CMD_WR_EEPROM) & ~bs1_w;
	wire go_fuse  = wr_fall & (cmd_r == `PPP_CMD_WR_FUSE) & ~(bs1_w & bs2_w);
	wire go_lock  = wr_fall & (cmd_r == `PPP_CMD_WR_LOCK);

	// Lock update: only clears bits, boot field frozen in mode 3
	wire       lock_mode3 = ((lock_r & `PPP_LOCK_MAIN) == 8'h00);
	wire [7:0] lock_keep  = lock_mode3 ? `PPP_LOCK_BOOT : 8'h00;
	wire [7:0] lock_new   = lock_r & (dat_lo_r | lock_keep);

	////////////////////////////////////////////////////////////////////////////
	// Read data selection
	wire [15:0] fword_rd = flash_r[faddr_w];
	wire [7:0]  flash_rd = bs1_w ? fword_rd[15:8] : fword_rd[7:0];
	wire [7:0]  fuse_rd  = ({bs2_w, bs1_w} == 2'h0) ? fuse_lo_r :
			({bs2_w, bs1_w} == 2'h3) ? fuse_hi_r :
			({bs2_w, bs1_w} == 2'h2) ? fuse_ext_r : lock_r;
	wire [7:0]  sig_rd   = (addr_lo_r == 8'h00) ? ID_BYTE0 :
			(addr_lo_r == 8'h01) ? ID_BYTE1 :
			(addr_lo_r == 8'h02) ? ID_BYTE2 : `PPP_BYTE_ERASED;
	wire        cal_sel  = bs1_w & (addr_lo_r == 8'h00);
	wire [7:0]  id_rd    = cal_sel ? CAL_BYTE :
			bs1_w ? `PPP_BYTE_ERASED : sig_rd;
	wire [7:0]  ee_rd    = bs1_w ? `PPP_BYTE_ERASED : eeprom_r[eaddr_w];
	wire [7:0]  rd_w     = (cmd_r == `PPP_CMD_RD_FLASH)  ? flash_rd :
			(cmd_r == `PPP_CMD_RD_EEPROM) ? ee_rd :
			(cmd_r == `PPP_CMD_RD_FUSE)   ? fuse_rd :
			(cmd_r == `PPP_CMD_RD_ID)     ? id_rd : `PPP_BYTE_ERASED;

	assign data_out       = dout_r;
	assign data_oe        = doe_r;
	assign ready_not_busy = rdy_r;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		unique case (state_r)
			ppp_pkg::ST_IDLE: begin
				if (go_flash) begin
					state_nxt = ppp_pkg::ST_COPY_FL;
				end else if (go_ee) begin
					state_nxt = ppp_pkg::ST_COPY_EE;
				end else if (go_fuse | go_lock) begin
					state_nxt = ppp_pkg::ST_HOLD;
					cnt_nxt   = CNT_W'(BUSY_CYCLES - 1);
				end
			end
			ppp_pkg::ST_COPY_FL: begin
				if (idx_r == FLASH_PWB'(PAGE_WORDS - 1)) begin
					state_nxt = ppp_pkg::ST_HOLD;
					cnt_nxt   = CNT_W'(BUSY_CYCLES - 1);
				end
			end
			ppp_pkg::ST_COPY_EE: begin
				if (idx_r == FLASH_PWB'(EE_PAGE - 1)) begin
					state_nxt = ppp_pkg::ST_HOLD;
					cnt_nxt   = CNT_W'(BUSY_CYCLES - 1);
				end
			end
			ppp_pkg::ST_HOLD: begin
				if (cnt_r == '0) begin
					state_nxt = ppp_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			default: begin
				state_nxt = ppp_pkg::ST_IDLE;
				cnt_nxt   = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer, ready flag and word index
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ppp_pkg::ST_IDLE;
			cnt_r   <= '0;
			idx_r   <= '0;
			rdy_r   <= 1'b1;
		end else if (clk_en) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			idx_r   <= (state_nxt == state_r) ? idx_r + FLASH_PWB'(1) : '0;
			rdy_r   <= (state_nxt == ppp_pkg::ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command, address and data latches; kept until reloaded
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_d_r  <= `PPP_PIN_RST;
			cmd_r     <= `PPP_CMD_NOP;
			addr_lo_r <= 8'h00;
			addr_hi_r <= 8'h00;
			dat_lo_r  <= `PPP_BYTE_ERASED;
			dat_hi_r  <= `PPP_BYTE_ERASED;
		end else if (clk_en) begin
			pins_d_r <= pins_w;
			if (ld_cmd & cmd_known) begin
				cmd_r <= bus_w;
			end
			if (ld_addr & ~bs1_w) begin
				addr_lo_r <= bus_w;
			end
			if (ld_addr & bs1_w) begin
				addr_hi_r <= bus_w;
			end
			if (ld_data & ~bs1_w) begin
				dat_lo_r <= bus_w;
			end
			if (ld_data & bs1_w) begin
				dat_hi_r <= bus_w;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Page target captured at the write strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			page_r  <= '0;
			epage_r <= '0;
		end else if (clk_en & wr_fall) begin
			page_r  <= fpage_w;
			epage_r <= epage_w;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fuse and lock bytes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fuse_lo_r  <= `PPP_FUSE_LO_RST;
			fuse_hi_r  <= `PPP_FUSE_HI_RST;
			fuse_ext_r <= `PPP_FUSE_EXT_RST;
			lock_r     <= `PPP_LOCK_RST;
		end else if (clk_en) begin
			if (go_fuse & ~bs1_w & ~bs2_w) begin
				fuse_lo_r <= dat_lo_r;
			end
			if (go_fuse & bs1_w & ~bs2_w) begin
				fuse_hi_r <= dat_lo_r;
			end
			if (go_fuse & ~bs1_w & bs2_w) begin
				fuse_ext_r <= dat_lo_r;
			end
			if (go_lock) begin
				lock_r <= lock_new;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data bus drive, only while output enable is low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_r <= 8'h00;
			doe_r  <= 1'b0;
		end else if (clk_en) begin
			dout_r <= rd_w;
			doe_r  <= oe_w;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Page buffers, one slot per entry
	genvar gi;
	generate
		for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_pbuf
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					pbuf_r[gi] <= 16'hFFFF;
				end else if (clk_en & pgl_rise & bs1_w & (fword_w == FLASH_PWB'(gi))) begin
					pbuf_r[gi] <= {dat_hi_r, dat_lo_r};
				end
			end
		end
		for (gi = 0; gi < EE_PAGE; gi++) begin : g_ebuf
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					ebuf_r[gi] <= `PPP_BYTE_ERASED;
				end else if (clk_en & pgl_rise & bs1_w & (eword_w == EE_PWB'(gi))) begin
					ebuf_r[gi] <= dat_lo_r;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Array programming, one word per cycle in the copy states
	always_ff @(posedge sys_clk) begin
		if (clk_en & (state_r == ppp_pkg::ST_COPY_FL)) begin
			flash_r[{page_r, idx_r}] <= pbuf_r[idx_r];
		end
		if (clk_en & (state_r == ppp_pkg::ST_COPY_EE)) begin
			eeprom_r[{epage_r, idx_r[EE_PWB-1:0]}] <= ebuf_r[idx_r[EE_PWB-1:0]];
		end
	end

endmodule : ppp_port

// *** sim/ppp_port_assertions.sv ***
// Port-level checks of the programming port
module ppp_port_checker #(
	parameter int FLASH_PWB   = 6,
	parameter int BUSY_CYCLES = 16
) (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic       action_strobe,
	input wire logic       action_select_hi,
	input wire logic       action_select_lo,
	input wire logic       byte_select_one,
	input wire logic       byte_select_two,
	input wire logic       page_latch_strobe,
	input wire logic       write_n,
	input wire logic       output_enable_n,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       ready_not_busy
);
	localparam int BMAX = 2 ** FLASH_PWB + BUSY_CYCLES + 4;
	logic [3:0]  wr_age_r;
	logic [15:0] busy_cnt_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	// Age of the last write-strobe low sample, length of the busy spell
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_age_r   <= 4'hF;
			busy_cnt_r <= 16'h0000;
		end else begin
			wr_age_r   <= !write_n ? 4'h0 : (wr_age_r == 4'hF ? wr_age_r : wr_age_r + 4'h1);
			busy_cnt_r <= ready_not_busy ? 16'h0000 : busy_cnt_r + 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Named sequences
	sequence s_oe_low;
		(!output_enable_n && clk_en) [*8];
	endsequence
	sequence s_oe_high;
		(output_enable_n && clk_en) [*8];
	endsequence
	sequence s_quiet;
		($stable({action_strobe, action_select_hi, action_select_lo, byte_select_one,
			byte_select_two, page_latch_strobe, write_n, output_enable_n})
			&& ready_not_busy && data_oe) [*8];
	endsequence
	property p_oe_on;    s_oe_low |-> data_oe; endproperty
	property p_oe_off;   s_oe_high |-> !data_oe; endproperty
	property p_rst_out;  $rose(rst_n) |-> ready_not_busy && !data_oe && data_out == 8'h00;
	endproperty
	property p_busy_why; $fell(ready_not_busy) |-> wr_age_r < 4'hA; endproperty
	property p_busy_max; !ready_not_busy |-> busy_cnt_r <= BMAX; endproperty
	property p_busy_min; $rose(ready_not_busy) |-> busy_cnt_r >= BUSY_CYCLES; endproperty
	property p_no_wr;    (write_n && ready_not_busy && clk_en) [*8] |=> ready_not_busy;
	endproperty
	property p_hold;     s_quiet |-> $stable(data_out); endproperty
	a_oe_on:    assert property (p_oe_on) else $error("bus not driven during read");
	a_oe_off:   assert property (p_oe_off) else $error("bus driven without read");
	a_rst_out:  assert property (p_rst_out) else $error("bad outputs after reset");
	a_busy_why: assert property (p_busy_why) else $error("busy without write");
	a_busy_max: assert property (p_busy_max) else $error("busy too long");
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	a_no_wr:    assert property (p_no_wr) else $error("busy while idle");
	a_hold:     assert property (p_hold) else $error("read data moved");
endmodule : ppp_port_checker

bind ppp_port ppp_port_checker #(.FLASH_PWB(FLASH_PWB), .BUSY_CYCLES(BUSY_CYCLES)) u_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .action_strobe(action_strobe),
	.action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
	.byte_select_one(byte_select_one), .byte_select_two(byte_select_two),
	.page_latch_strobe(page_latch_strobe), .write_n(write_n),
	.output_enable_n(output_enable_n), .data_in(data_in), .data_out(data_out),
	.data_oe(data_oe), .ready_not_busy(ready_not_busy));

// *** sim/ppp_prog_model.sv ***
// External programmer: drives pins on falling edges, holds each level 6 cycles, output enable low 10 cycles
module ppp_prog_model (
	input wire logic       sys_clk,
	input wire logic       ready_not_busy,
	input wire logic       data_oe,
	input wire logic [7:0] data_out,
	output logic           action_strobe,
	output logic           action_select_hi,
	output logic           action_select_lo,
	output logic           byte_select_one,
	output logic           byte_select_two,
	output logic           page_latch_strobe,
	output logic           write_n,
	output logic           output_enable_n,
	output logic     [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] drv_r;
	// Bus level: device when it drives, else programmer
	assign data_in = data_oe ? data_out : drv_r;
	initial begin
		{action_strobe, action_select_hi, action_select_lo, byte_select_one} = 4'h0;
		{byte_select_two, page_latch_strobe, write_n, output_enable_n} = 4'h3;
		drv_r = 8'h00;
	end
	task step;
		repeat (6) @(negedge sys_clk);
	endtask : step
	// Set selects and data, then pulse the action strobe
	task ld(input logic [1:0] a, input logic s1, input logic [7:0] d);
		{action_select_hi, action_select_lo} = a;
		byte_select_one = s1;
		drv_r = d;
		step;
		action_strobe = 1'b1;
		step;
		action_strobe = 1'b0;
		step;
	endtask : ld
	// Store loaded data into the page buffer
	task latch;
		byte_select_one = 1'b1;
		step;
		page_latch_strobe = 1'b1;
		step;
		page_latch_strobe = 1'b0;
		step;
	endtask : latch
	// Write pulse, then wait for ready; reports whether busy was seen
	task wr(input logic s1, input logic s2, output logic bsy);
		int n;
		{byte_select_one, byte_select_two} = {s1, s2};
		step;
		bsy = 1'b0;
		write_n = 1'b0;
		for (n = 0; n < 120; n++) begin
			@(negedge sys_clk);
			if (n == 5) write_n = 1'b1;
			if (ready_not_busy === 1'b0) bsy = 1'b1;
			else if (bsy && n > 5) break;
		end
		step;
	endtask : wr
	// Read cycle; programmer's released level is the inverse of its last drive
	task rd(input logic s2, input logic s1, output logic [7:0] q);
		{byte_select_two, byte_select_one} = {s2, s1};
		drv_r = ~drv_r;
		output_enable_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		q = data_in;
		output_enable_n = 1'b1;
		step;
	endtask : rd
endmodule : ppp_prog_model

// *** sim/ppp_port_tb_top.sv ***
module ppp_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] IDV [3] = '{8'h6B, 8'h29, 8'hD4}; // Arbitrary values
	localparam logic [7:0] CALV = 8'h47; // Arbitrary value
	logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
	logic as, xh, xl, b1, b2, pl, wn, oe, doe, rdy;
	logic [7:0] din, dout;
	int fail_count = 0, num_checks = 0;
	always #20 sys_clk = ~sys_clk;
	ppp_port #(.FLASH_AW(8), .FLASH_PWB(3), .EE_AW(5), .EE_PWB(2), .BUSY_CYCLES(2),
		.ID_BYTE0(IDV[0]), .ID_BYTE1(IDV[1]), .ID_BYTE2(IDV[2]), .CAL_BYTE(CALV)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .action_strobe(as),
		.action_select_hi(xh), .action_select_lo(xl), .byte_select_one(b1),
		.byte_select_two(b2), .page_latch_strobe(pl), .write_n(wn), .output_enable_n(oe),
		.data_in(din), .data_out(dout), .data_oe(doe), .ready_not_busy(rdy));
	ppp_prog_model m (.sys_clk(sys_clk), .ready_not_busy(rdy), .data_oe(doe),
		.data_out(dout), .action_strobe(as), .action_select_hi(xh), .action_select_lo(xl),
		.byte_select_one(b1), .byte_select_two(b2), .page_latch_strobe(pl), .write_n(wn),
		.output_enable_n(oe), .data_in(din));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t byte %h expected %h", $time, g, e);
		end
	endtask : chk
	task chkb(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t busy flag %b expected %b", $time, g, e);
		end
	endtask : chkb
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////////////
	// Fill flash page 1, program it, end session, read back
	task t_flash;
		logic [7:0] q, k;
		logic       b;
		m.ld(2'h2, 1'b0, 8'h10);
		for (k = 8'h00; k < 8'h08; k++) begin
			m.ld(2'h0, 1'b0, 8'h08 + k);
			m.ld(2'h1, 1'b0, 8'h10 + k);
			m.ld(2'h1, 1'b1, 8'hA0 + k);
			m.latch;
		end
		m.ld(2'h0, 1'b1, 8'h00);
		m.wr(1'b0, 1'b0, b);
		chkb(b, 1'b1);
		m.ld(2'h2, 1'b0, 8'h00);
		m.wr(1'b0, 1'b0, b);
		chkb(b, 1'b0);
		m.ld(2'h2, 1'b0, 8'h02);
		for (k = 8'h00; k < 8'h08; k++) begin
			m.ld(2'h0, 1'b0, 8'h08 + k);
			m.rd(1'b0, 1'b0, q);
			chk(q, 8'h10 + k);
			m.rd(1'b0, 1'b1, q);
			chk(q, 8'hA0 + k);
		end
	endtask : t_flash
	// Program one EEPROM page and read it back
	task t_eeprom;
		logic [7:0] q, k;
		logic       b;
		m.ld(2'h2, 1'b0, 8'h11);
		m.ld(2'h0, 1'b1, 8'h00);
		for (k = 8'h00; k < 8'h04; k++) begin
			m.ld(2'h0, 1'b0, 8'h04 + k);
			m.ld(2'h1, 1'b0, 8'hC0 + k);
			m.latch;
		end
		m.wr(1'b0, 1'b0, b);
		chkb(b, 1'b1);
		m.ld(2'h2, 1'b0, 8'h03);
		for (k = 8'h00; k < 8'h04; k++) begin
			m.ld(2'h0, 1'b0, 8'h04 + k);
			m.rd(1'b0, 1'b0, q);
			chk(q, 8'hC0 + k);
		end
	endtask : t_eeprom
	// Write the three fuse bytes, read all back, lock reset value first
	task t_fuse;
		logic [7:0] q;
		logic [7:0] fv [3];
		logic       b;
		int         k;
		fv = '{8'hA5, 8'h5A, 8'h3C};
		m.ld(2'h2, 1'b0, 8'h04);
		m.rd(1'b0, 1'b1, q);
		chk(q, 8'hFF);
		m.ld(2'h2, 1'b0, 8'h40);
		for (k = 0; k < 3; k++) begin
			m.ld(2'h1, 1'b0, fv[k]);
			m.wr(k == 1, k == 2, b);
			chkb(b, 1'b1);
		end
		m.ld(2'h2, 1'b0, 8'h04);
		m.rd(1'b0, 1'b0, q);
		chk(q, fv[0]);
		m.rd(1'b1, 1'b1, q);
		chk(q, fv[1]);
		m.rd(1'b1, 1'b0, q);
		chk(q, fv[2]);
	endtask : t_fuse
	// Enter lock mode 3, then try boot bits and clearing
	task t_lock;
		logic [7:0] q;
		logic       b;
		m.ld(2'h2, 1'b0, 8'h20);
		m.ld(2'h1, 1'b0, 8'hFC);
		m.wr(1'b0, 1'b0, b);
		m.ld(2'h1, 1'b0, 8'hC0);
		m.wr(1'b0, 1'b0, b);
		m.ld(2'h1, 1'b0, 8'hFF);
		m.wr(1'b0, 1'b0, b);
		m.ld(2'h2, 1'b0, 8'h04);
		m.rd(1'b0, 1'b1, q);
		chk(q, 8'hFC);
	endtask : t_lock
	// Identification and calibration, then ignored strobes
	task t_sig;
		logic [7:0] q, k;
		m.ld(2'h2, 1'b0, 8'h08);
		for (k = 8'h00; k < 8'h03; k++) begin
			m.ld(2'h0, 1'b0, k);
			m.rd(1'b0, 1'b0, q);
			chk(q, IDV[k]);
		end
		m.ld(2'h0, 1'b0, 8'h00);
		m.rd(1'b0, 1'b1, q);
		chk(q, CALV);
		m.ld(2'h3, 1'b0, 8'h02);
		m.ld(2'h2, 1'b0, 8'h55);
		m.rd(1'b0, 1'b1, q);
		chk(q, CALV);
	endtask : t_sig
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		m.step;
		t_flash;
		t_eeprom;
		t_fuse;
		t_lock;
		t_sig;
		test_done;
	end
	// Watchdog well beyond the expected run
	initial begin
		#800000;
		fail_count++;
		test_done;
	end
endmodule : ppp_port_tb_top
